// ---- shared/adcsr_consts.svh ----
// constants for the serial converter readout block
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH

// ***********************************************************
// result format
// ***********************************************************
`define ADCSR_RES_W      16
`define ADCSR_AIN_W      17
`define ADCSR_POS_FS     16'h7FFF
`define ADCSR_NEG_FS     16'h8000
`define ADCSR_ZERO       16'h0000
`define ADCSR_SIGN_FLIP  16'h8000
`define ADCSR_BIT_MSB    4'hF

// ***********************************************************
// link framing
// ***********************************************************
`define ADCSR_OE_EDGE    3'h5
`define ADCSR_EDGE_W     3

// ***********************************************************
// timing
// ***********************************************************
`define ADCSR_CLK_MHZ    100
`define ADCSR_ACQ_NS     20
`define ADCSR_ACQ_CYC    ((`ADCSR_ACQ_NS * `ADCSR_CLK_MHZ + 999) / 1000)

`endif

// ---- shared/adcsr_pkg.sv ----
// types shared by the serial converter readout block
`default_nettype none
package adcsr_pkg;

   typedef enum logic [1:0]
   {
      ADCSR_ST_SLEEP  = 2'b00,
      ADCSR_ST_HOLD   = 2'b01,
      ADCSR_ST_CONV   = 2'b10,
      ADCSR_ST_DONE   = 2'b11
   } adcsr_state_t;

   typedef logic [15:0]        adcsr_code_t;
   typedef logic signed [16:0] adcsr_ain_t;

endpackage : adcsr_pkg

`default_nettype wire

// ---- shared/adcsr_conv_if.sv ----
// carrier between frame control and the converter engine
`timescale 1ns/1ps
`default_nettype none

interface adcsr_conv_if;
   import adcsr_pkg::*;

   logic        start;
   adcsr_ain_t  ain;
   logic        busy;
   logic        done;
   adcsr_code_t result;

   modport ctrl
   (
      output start,
      output ain,
      input  busy,
      input  done,
      input  result
   );

   modport engine
   (
      input  start,
      input  ain,
      output busy,
      output done,
      output result
   );
endinterface : adcsr_conv_if

`default_nettype wire

// ---- src/adcsr_conv.sv ----
// successive approximation engine with automatic power down
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_consts.svh"

module adcsr_conv
(
   // clock and reset
   input  wire logic   core_clk,
   input  wire logic   srst,
   // converter carrier
   adcsr_conv_if.engine cv
);
   import adcsr_pkg::*;

   adcsr_state_t state_r,  state_nxt;
   adcsr_code_t  hold_r,   hold_nxt;
   adcsr_code_t  code_r,   code_nxt;
   adcsr_code_t  res_r,    res_nxt;
   logic [3:0]   bit_r,    bit_nxt;
   logic [3:0]   acq_r,    acq_nxt;
   logic         done_r,   done_nxt;
   adcsr_code_t  trial;

   // ***********************************************************
   // input clamp to the code range
   // ***********************************************************
   function automatic adcsr_code_t clamp(input adcsr_ain_t v);
      if (v > $signed({1'b0, `ADCSR_POS_FS}))
         clamp = `ADCSR_POS_FS;
      else if (v < $signed({1'b1, `ADCSR_NEG_FS}))
         clamp = `ADCSR_NEG_FS;
      else
         clamp = v[15:0];
   endfunction : clamp

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb
   begin
      state_nxt = state_r;
      hold_nxt  = hold_r;
      code_nxt  = code_r;
      res_nxt   = res_r;
      bit_nxt   = bit_r;
      acq_nxt   = acq_r;
      done_nxt  = done_r;
      trial     = code_r | (16'h0001 << bit_r);
      case (state_r)
         ADCSR_ST_SLEEP:
         begin
            if (cv.start)
            begin
               // sample on this start pulse; clamp over/underrange
               hold_nxt  = clamp(cv.ain) ^ `ADCSR_SIGN_FLIP;
               code_nxt  = `ADCSR_ZERO;
               bit_nxt   = `ADCSR_BIT_MSB;
               acq_nxt   = 4'(`ADCSR_ACQ_CYC);
               done_nxt  = 1'b0;
               state_nxt = ADCSR_ST_HOLD;
            end
         end
         ADCSR_ST_HOLD:
         begin
            // switches open before the first trial
            if (acq_r <= 4'h1)
               state_nxt = ADCSR_ST_CONV;
            else
               acq_nxt = acq_r - 4'h1;
         end
         ADCSR_ST_CONV:
         begin
            if (trial <= hold_r)
               code_nxt = trial;
            if (bit_r == 4'h0)
               state_nxt = ADCSR_ST_DONE;
            else
               bit_nxt = bit_r - 4'h1;
         end
         ADCSR_ST_DONE:
         begin
            res_nxt   = code_r ^ `ADCSR_SIGN_FLIP;
            done_nxt  = 1'b1;
            state_nxt = ADCSR_ST_SLEEP;
         end
         default:
            state_nxt = ADCSR_ST_SLEEP;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_r <= ADCSR_ST_SLEEP;
         hold_r  <= `ADCSR_ZERO;
         code_r  <= `ADCSR_ZERO;
         res_r   <= `ADCSR_ZERO;
         bit_r   <= 4'h0;
         acq_r   <= 4'h0;
         done_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         hold_r  <= hold_nxt;
         code_r  <= code_nxt;
         res_r   <= res_nxt;
         bit_r   <= bit_nxt;
         acq_r   <= acq_nxt;
         done_r  <= done_nxt;
      end
   end

   assign cv.busy   = (state_r != ADCSR_ST_SLEEP);
   assign cv.done   = done_r;
   assign cv.result = res_r;

endmodule : adcsr_conv

`default_nettype wire

// ---- src/adcsr_top.sv ----
// serial readout of a sampling converter: core control and link shifter
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_consts.svh"

module adcsr_top
(
   // core clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // link pins
   input  wire logic              serial_shift_clock,
   input  wire logic              cs_n,
   output logic                   dout,
   output logic                   dout_oe,
   // analog front end, already digitised level
   input  wire adcsr_pkg::adcsr_ain_t ain_level,
   // status
   output logic                   pwr_down
);
   import adcsr_pkg::*;

   // two domains: core_clk runs the engine and the frame start,
   // the host's shift clock runs the pins; only the valid flag
   // and chip select cross through stages, the result word waits still behind the flag
   // and is read once, at the fifth edge

   // ***********************************************************
   // helpers
   // ***********************************************************
   // a change counts once stages two and three agree, so a
   // metastable first stage never reaches the logic behind
   function automatic logic settle
   (
      input logic [2:0] stages,
      input logic       level
   );
      if (stages[1] == stages[2])
         settle = stages[2];
      else
         settle = level;
   endfunction : settle

   // start pulse pending or in flight: the done flag of the last
   // frame must not count as this frame's result
   function automatic logic opening
   (
      input logic pend,
      input logic sent
   );
      opening = pend || sent;
   endfunction : opening

   // ***********************************************************
   // carrier to the engine
   // ***********************************************************
   adcsr_conv_if cv ();

   // ***********************************************************
   // core side: chip select synchroniser
   // ***********************************************************
   // three stages: cs_n is a pin with no relation to core_clk
   logic [2:0] cs_sync_r, cs_sync_nxt;
   logic       cs_lvl_r,  cs_lvl_nxt;
   logic       start_r,   start_nxt;
   logic       valid_r,   valid_nxt;
   logic       pwr_r,     pwr_nxt;
   adcsr_ain_t ain_r,     ain_nxt;

   always_comb
   begin
      cs_sync_nxt = {cs_sync_r[1:0], cs_n};
      cs_lvl_nxt  = settle(cs_sync_r, cs_lvl_r);
      start_nxt   = 1'b0;
      valid_nxt   = valid_r;
      ain_nxt     = ain_level;
      // chip select fall starts a conversion
      if (cs_lvl_r && !cs_lvl_nxt)
         start_nxt = 1'b1;
      // result word stays still while valid is high
      if (cs_lvl_nxt)
         valid_nxt = 1'b0;
      else if (cv.done && !cv.busy && !opening(start_nxt, start_r))
         valid_nxt = 1'b1;
      // low power whenever the engine is idle and no start pulse is pending or in flight
      pwr_nxt = !cv.busy && !opening(start_nxt, start_r);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cs_sync_r <= 3'h7;
         cs_lvl_r  <= 1'b1;
         start_r   <= 1'b0;
         valid_r   <= 1'b0;
         pwr_r     <= 1'b1;
         ain_r     <= '0;
      end
      else
      begin
         cs_sync_r <= cs_sync_nxt;
         cs_lvl_r  <= cs_lvl_nxt;
         start_r   <= start_nxt;
         valid_r   <= valid_nxt;
         pwr_r     <= pwr_nxt;
         ain_r     <= ain_nxt;
      end
   end

   // front end level tracked each cycle; taken on the start pulse
   assign cv.start = start_r;
   assign cv.ain   = ain_r;

   // ***********************************************************
   // core side: conversion engine
   // ***********************************************************
   // the engine powers itself down when its conversion ends
   adcsr_conv adcsr_conv_i
   (
      .core_clk (core_clk),
      .srst     (srst),
      .cv       (cv.engine)
   );

   // ***********************************************************
   // link side: result valid crossing
   // ***********************************************************
   // the shift clock stops outside frames, so everything here is
   // cleared by chip select high instead of by a clocked reset;
   // the result word itself is not staged: it stands still from
   // before valid rises until the next frame opens
   logic [2:0] vld_sync_r, vld_sync_nxt;
   logic       vld_lvl_r,  vld_lvl_nxt;

   always_comb
   begin
      vld_sync_nxt = {vld_sync_r[1:0], valid_r};
      vld_lvl_nxt  = settle(vld_sync_r, vld_lvl_r);
   end

   always_ff @(negedge serial_shift_clock or posedge cs_n)
   begin
      if (cs_n)
      begin
         vld_sync_r <= 3'h0;
         vld_lvl_r  <= 1'b0;
      end
      else
      begin
         vld_sync_r <= vld_sync_nxt;
         vld_lvl_r  <= vld_lvl_nxt;
      end
   end

   // ***********************************************************
   // link side: edge count and shifter
   // ***********************************************************
   logic [`ADCSR_EDGE_W-1:0] edge_r,  edge_nxt;
   adcsr_code_t              shift_r, shift_nxt;
   logic                     dout_r,  dout_nxt;
   logic                     oe_r,    oe_nxt;

   always_comb
   begin
      edge_nxt  = edge_r;
      shift_nxt = shift_r;
      dout_nxt  = dout_r;
      oe_nxt    = oe_r;
      // count stops at five; later edges only move the shifter
      if (edge_r != `ADCSR_OE_EDGE)
         edge_nxt = edge_r + `ADCSR_EDGE_W'(1);
      if (edge_nxt == `ADCSR_OE_EDGE && edge_r != `ADCSR_OE_EDGE)
      begin
         // enable and force low at fifth edge
         oe_nxt    = 1'b1;
         dout_nxt  = 1'b0;
         // word of this frame; zero if not yet ready
         // limitation: a host that reaches edge five too early
         // reads zeros rather than a stale word of the last frame,
         // traded for never showing another frame's sample
         shift_nxt = vld_lvl_r ? cv.result : `ADCSR_ZERO;
      end
      else if (oe_r)
      begin
         dout_nxt  = shift_r[`ADCSR_RES_W-1];
         shift_nxt = {shift_r[`ADCSR_RES_W-2:0], 1'b0};
      end
   end

   always_ff @(negedge serial_shift_clock or posedge cs_n)
   begin
      // released while chip select is high
      // a cut frame ends here at once, mid-word or not
      if (cs_n)
      begin
         edge_r  <= '0;
         shift_r <= `ADCSR_ZERO;
         dout_r  <= 1'b0;
         oe_r    <= 1'b0;
      end
      else
      begin
         edge_r  <= edge_nxt;
         shift_r <= shift_nxt;
         dout_r  <= dout_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // ***********************************************************
   // pins and status
   // ***********************************************************
   // dout means something only while dout_oe is high; the pad
   // turns a low enable into a released line
   assign dout     = dout_r;
   assign dout_oe  = oe_r;
   // pwr_down rises one cycle after the engine idles and falls with the start pulse, one cycle before it wakes
   assign pwr_down = pwr_r;

endmodule : adcsr_top

`default_nettype wire

// ---- bench/adcsr_top_properties.sv ----
// port checker of the serial readout block
`timescale 1ns/1ps
`default_nettype none
module adcsr_props
(
   // core side
   input wire logic                  core_clk,
   input wire logic                  srst,
   // link pins
   input wire logic                  serial_shift_clock,
   input wire logic                  cs_n,
   input wire logic                  dout,
   input wire logic                  dout_oe,
   // level and status
   input wire adcsr_pkg::adcsr_ain_t ain_level,
   input wire logic                  pwr_down
);
   import adcsr_pkg::*;
   logic [4:0]  cnt_r;
   adcsr_code_t sh_r;
   adcsr_ain_t  cap_r;
   adcsr_code_t exp_code;
   assign exp_code = (cap_r > 17'sh07FFF) ? 16'h7FFF : (cap_r < 17'sh18000) ? 16'h8000 : cap_r[15:0];
   // falling edges since select; cleared while deselected
   always_ff @(negedge serial_shift_clock or posedge cs_n)
      if (cs_n)
         cnt_r <= 5'h00;
      else if (cnt_r != 5'h1F)
         cnt_r <= cnt_r + 5'h01;
   // shift on rising edge: the design moves dout on the falling one
   always_ff @(posedge serial_shift_clock)
      if (cnt_r >= 5'h06 && cnt_r <= 5'h15)
         sh_r <= {sh_r[14:0], dout};
   always_ff @(posedge core_clk)
      if ($fell(cs_n))
         cap_r <= ain_level;
   property p_oe_off;
      @(posedge core_clk) disable iff (srst) cs_n |-> !dout_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
   property p_oe_quiet;
      @(negedge serial_shift_clock) disable iff (cs_n) cnt_r < 5'h05 |-> !dout_oe;
   endproperty
   a_oe_quiet: assert property (p_oe_quiet) else $error("output enabled before fifth edge");
   property p_oe_lead;
      @(negedge serial_shift_clock) disable iff (cs_n) cnt_r == 5'h05 |-> dout_oe && !dout;
   endproperty
   a_oe_lead: assert property (p_oe_lead) else $error("no low lead bit at fifth edge");
   property p_oe_hold;
      @(negedge serial_shift_clock) disable iff (cs_n) cnt_r > 5'h05 |-> dout_oe;
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("output dropped inside frame");
   property p_tail;
      @(negedge serial_shift_clock) disable iff (cs_n) cnt_r >= 5'h16 |-> !dout;
   endproperty
   a_tail: assert property (p_tail) else $error("data after last bit not low");
   property p_word;
      @(negedge serial_shift_clock) disable iff (cs_n) cnt_r == 5'h16 |-> sh_r == exp_code;
   endproperty
   a_word: assert property (p_word) else $error("shifted word differs from sampled level");
   property p_wake;
      @(posedge core_clk) disable iff (srst) $fell(cs_n) |-> ##[1:10] !pwr_down ##[5:60] pwr_down;
   endproperty
   a_wake: assert property (p_wake) else $error("no automatic power down after conversion");
   property p_rst_sleep;
      @(posedge core_clk) srst |=> pwr_down;
   endproperty
   a_rst_sleep: assert property (p_rst_sleep) else $error("not powered down in reset");
   c_frame: cover property (@(negedge serial_shift_clock) cnt_r == 5'h16);
   c_top: cover property (@(negedge serial_shift_clock) cnt_r == 5'h16 && exp_code == 16'h7FFF);
   c_bot: cover property (@(negedge serial_shift_clock) cnt_r == 5'h16 && exp_code == 16'h8000);
endmodule : adcsr_props
bind adcsr_top adcsr_props adcsr_props_i (.core_clk(core_clk), .srst(srst), .serial_shift_clock(serial_shift_clock),
   .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .ain_level(ain_level), .pwr_down(pwr_down));
`default_nettype wire

// ---- bench/adcsr_host_model.sv ----
// host controller model reading one word per frame
`timescale 1ns/1ps
`default_nettype none
module adcsr_host_model
(
   // bench control
   input wire logic   go,
   output logic       busy,
   // link pins
   output logic       cs_n,
   output logic       serial_shift_clock,
   input wire logic   dout,
   input wire logic   dout_oe,
   // captured frame
   output logic [15:0] word,
   output logic [3:0]  flags,
   output logic        word_vld
);
   logic line;
   logic last_r;
   logic [15:0] wfall;
   int   k;
   // released line shows inverse of last value, never a lucky match
   assign line = dout_oe ? dout : ~last_r;
   always @(dout or dout_oe)
      if (dout_oe)
         last_r = dout;
   initial
   begin
      serial_shift_clock = 1'b1;
      {word, wfall, flags, word_vld, busy, last_r} = '0;
      // a clean rise clears the link side, which has no other reset
      #1 cs_n = 1'b1;
      forever
      begin
         @(posedge go);
         busy = 1'b1;
         flags = 4'h0;
         // select fall opens conversion and transfer
         #3.3 cs_n = 1'b0;
         #450;
         for (k = 1; k <= 23; k++)
         begin
            #7.5 serial_shift_clock = 1'b0;
            // falling-edge capture: bit of the edge before still stands
            if (k >= 7 && k <= 22)
               wfall = {wfall[14:0], line};
            #7.5 serial_shift_clock = 1'b1;
            // capture on rising edge; bit stands across both
            if (k < 5 && dout_oe !== 1'b0)
               flags[0] = 1'b1;
            if (k == 5 && !(dout_oe === 1'b1 && line === 1'b0))
               flags[1] = 1'b1;
            if (k >= 6 && k <= 21)
               word = {word[14:0], line};
            if (k >= 22 && line !== 1'b0)
               flags[2] = 1'b1;
         end
         // both capture edges must yield the same word
         if (wfall !== word)
            flags[2] = 1'b1;
         #7.5 cs_n = 1'b1;
         #1 flags[3] = (dout_oe !== 1'b0);
         word_vld = 1'b1;
         #1 word_vld = 1'b0;
         busy = 1'b0;
      end
   end
endmodule : adcsr_host_model
`default_nettype wire

// ---- bench/tb_adc_serial_readout.sv ----
// self-checking bench of the serial readout block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_readout;
   import adcsr_pkg::*;
   logic        core_clk, srst, go, sclk, cs_n, dout, dout_oe, pwr_down, vld, busy;
   adcsr_ain_t  ain;
   adcsr_code_t word;
   logic [3:0]  flags;
   adcsr_code_t exp_q[$];
   int          errors, comparisons, cyc;
   logic [15:0] lfsr;
   adcsr_ain_t  tbl[9] = '{17'h00000, 17'h00001, 17'h1FFFF, 17'h07FFF, 17'h08000,
                           17'h18000, 17'h17FFF, 17'h0FFFF, 17'h10000};
   adcsr_top adcsr_top_i (.core_clk(core_clk), .srst(srst), .serial_shift_clock(sclk), .cs_n(cs_n),
      .dout(dout), .dout_oe(dout_oe), .ain_level(ain), .pwr_down(pwr_down));
   adcsr_host_model adcsr_host_model_i (.go(go), .busy(busy), .cs_n(cs_n), .serial_shift_clock(sclk),
      .dout(dout), .dout_oe(dout_oe), .word(word), .flags(flags), .word_vld(vld));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   // two's complement, saturating at both limits
   function automatic adcsr_code_t clamp(input adcsr_ain_t v);
      return (v > 17'sh07FFF) ? 16'h7FFF : (v < 17'sh18000) ? 16'h8000 : v[15:0];
   endfunction : clamp
   task automatic cmp_word(input adcsr_code_t got, input adcsr_code_t want);
      comparisons++;
      if (got !== want)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : cmp_word
   task automatic cmp_flags(input logic [3:0] got, input logic [3:0] want);
      comparisons++;
      if (got !== want)
      begin
         errors++;
         $display("ERROR t=%0t flags=%h exp=%h", $time, got, want);
      end
   endtask : cmp_flags
   task automatic summarize;
      // frames whose words never came back count as one mismatch in all
      if (exp_q.size() != 0)
         errors++;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // level changes every frame, so a one-frame lag shows wherever two frames in a row clamp to different codes
   task automatic run_frame(input adcsr_ain_t v);
      int n;
      ain <= v;
      exp_q.push_back(clamp(v));
      @(posedge core_clk);
      go <= 1'b1;
      repeat (2) @(posedge core_clk);
      go <= 1'b0;
      for (n = 0; n < 300 && busy; n++)
         @(posedge core_clk);
      // host stuck in a frame: the limit ran out
      if (busy)
         errors++;
      repeat (6) @(posedge core_clk);
   endtask : run_frame
   always @(posedge vld)
   begin
      cmp_word(word, exp_q.pop_front());
      cmp_flags(flags, 4'h0);
   end
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         errors++;
         summarize();
      end
   end
   initial
   begin
      srst = 1'b1;
      go = 1'b0;
      ain = '0;
      errors = 0;
      comparisons = 0;
      cyc = 0;
      lfsr = 16'h5B9B;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      repeat (6) @(posedge core_clk);
      foreach (tbl[i])
         run_frame(tbl[i]);
      repeat (6)
      begin
         lfsr = lfsr_next(lfsr);
         run_frame({lfsr[3], lfsr});
      end
      repeat (4) @(posedge core_clk);
      summarize();
   end
endmodule : tb_adc_serial_readout
`default_nettype wire
